/* File: rtl/gtm_pkg.sv */
package gtm_pkg;

  // ==========================================================
  // register map, byte addresses
  localparam logic [7:0] OFF_CTL   = 8'h00;
  localparam logic [7:0] OFF_PER   = 8'h04;
  localparam logic [7:0] OFF_CNT   = 8'h08;
  localparam logic [7:0] OFF_CMP   = 8'h0C;
  localparam logic [7:0] OFF_GRP   = 8'h10;
  localparam logic [7:0] OFF_FLG   = 8'h14;

  // ==========================================================
  // timer_control fields
  localparam int CTL_CMPEN  = 1;
  localparam int CTL_CLKS   = 4;
  localparam int CTL_EN     = 6;
  localparam int CTL_PRE    = 8;
  localparam int CTL_MODE   = 11;
  localparam logic [1:0] CLKS_EXT  = 2'h1;
  localparam logic [2:0] MODE_DIR  = 3'h3;
  localparam logic [2:0] MODE_SUD  = 3'h4;

  // timer_group_control and flag fields
  localparam int GRP_DIR    = 0;
  localparam int GRP_CMPOUT = 1;
  localparam int FLG_PER    = 0;
  localparam int FLG_UND    = 1;
  localparam int FLG_OVF    = 2;
  localparam int FLG_CMP    = 3;

  // ==========================================================
  // reset values and limits
  localparam logic [15:0] CTL_RST = 16'h0000;
  localparam logic [15:0] PER_RST = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;

  // direction pipe stages; dir takes the new level three clk_sys cycles after a prescale period ends
  localparam int DIR_LAT = 2;

  // ==========================================================
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } gtm_apb_req_t;

  typedef struct packed {
    logic [15:0] ctl;
    logic [15:0] per;
    logic [15:0] cnt;
    logic [15:0] cmp;
    logic [3:0]  flg;
    logic [6:0]  psc;
    logic        up;
    logic        dir;
    logic [1:0]  dpv;
    logic [1:0]  dpl;
    logic [2:0]  cks;
    logic        ckl;
    logic [2:0]  drs;
    logic        drl;
    logic [1:0]  mt;
    logic        cmpo;
    logic [31:0] rdata;
    logic        err;
  } gtm_state_t;

endpackage

/* File: rtl/gtm_timer.sv */
`timescale 1ns/1ps

module gtm_timer (
  // clock and reset
  input  logic                  clk_sys,
  input  logic                  nrst,
  // apb slave
  input  gtm_pkg::gtm_apb_req_t apb_req,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  // pins from the quadrature_decoder
  input  logic                  ext_clk_pin,
  input  logic                  count_direction_input,
  // status
  output logic                  cmp_out,
  output logic                  dir_status,
  output logic                  timer_running
);

  gtm_pkg::gtm_state_t s_q;
  gtm_pkg::gtm_state_t s_d;

  logic        en;
  logic        dirm;
  logic        sudm;
  logic        src_tick;
  logic        tick;
  logic [6:0]  psc_lim;
  logic [15:0] nxt;
  logic        up_n;
  logic        stop;
  logic        wr;
  logic        rd_setup;
  logic [3:0]  fset;
  logic [3:0]  fclr;
  logic        match;

  assign pready        = 1'b1;
  assign prdata        = s_q.rdata;
  assign pslverr       = s_q.err;
  assign cmp_out       = s_q.cmpo;
  assign timer_running = s_q.ctl[gtm_pkg::CTL_EN];

  always_comb
  begin
    s_d      = s_q;
    en       = s_q.ctl[gtm_pkg::CTL_EN];
    dirm     = (s_q.ctl[gtm_pkg::CTL_MODE +: 3] == gtm_pkg::MODE_DIR);
    sudm     = (s_q.ctl[gtm_pkg::CTL_MODE +: 3] == gtm_pkg::MODE_SUD);
    wr       = apb_req.psel & apb_req.penable & apb_req.pwrite;
    rd_setup = apb_req.psel & ~apb_req.penable;
    fset     = 4'h0;
    fclr     = 4'h0;
    nxt      = s_q.cnt;
    up_n     = s_q.up;
    stop     = 1'b0;
    match    = 1'b0;

    // ==========================================================
    // pin synchronisers; a level counts once stages two and three agree
    s_d.cks = {s_q.cks[1:0], ext_clk_pin};
    s_d.drs = {s_q.drs[1:0], count_direction_input};
    if (s_q.cks[1] == s_q.cks[2])
    begin
      s_d.ckl = s_q.cks[2];
    end
    if (s_q.drs[1] == s_q.drs[2])
    begin
      s_d.drl = s_q.drs[2];
    end

    // ==========================================================
    // clock select and prescaler
    if (s_q.ctl[gtm_pkg::CTL_CLKS +: 2] == gtm_pkg::CLKS_EXT)
    begin
      src_tick = s_d.ckl & ~s_q.ckl;
    end
    else
    begin
      src_tick = 1'b1;
    end
    psc_lim = 7'((8'h01 << s_q.ctl[gtm_pkg::CTL_PRE +: 3]) - 8'h01);
    tick    = 1'b0;
    if (en && src_tick)
    begin
      if (s_q.psc == psc_lim)
      begin
        tick      = 1'b1;
        s_d.psc   = 7'h00;
      end
      else
      begin
        s_d.psc = s_q.psc + 7'h01;
      end
    end

    // ==========================================================
    // next count
    if (dirm)
    begin
      if (s_q.dir)
      begin
        if (s_q.cnt != s_q.per && s_q.cnt != gtm_pkg::CNT_MAX)
        begin
          nxt = s_q.cnt + 16'h0001;
        end
      end
      else if (s_q.cnt != 16'h0000)
      begin
        nxt = s_q.cnt - 16'h0001;
      end
    end
    else if (sudm)
    begin
      if (s_q.up)
      begin
        if (s_q.cnt == s_q.per)
        begin
          up_n = 1'b0;
          nxt  = (s_q.cnt == 16'h0000) ? 16'h0000 : s_q.cnt - 16'h0001;
        end
        else
        begin
          nxt = s_q.cnt + 16'h0001;
        end
      end
      else
      begin
        nxt = s_q.cnt - 16'h0001;
      end
      stop = ~up_n && (nxt == 16'h0000);
    end

    if (tick && (dirm || sudm))
    begin
      s_d.cnt = nxt;
      s_d.up  = up_n;
      // flag timing shared with single up/down mode
      fset[gtm_pkg::FLG_PER] = (nxt == s_q.per);
      fset[gtm_pkg::FLG_UND] = (nxt == 16'h0000);
      fset[gtm_pkg::FLG_OVF] = (nxt == gtm_pkg::CNT_MAX);
      match = s_q.ctl[gtm_pkg::CTL_CMPEN] && (nxt == s_q.cmp);
      if (sudm && stop)
      begin
        s_d.ctl[gtm_pkg::CTL_EN] = 1'b0;
        s_d.psc                  = 7'h00;
      end
    end

    // ==========================================================
    // direction pipe: pin level sampled at prescale end, used later
    s_d.dpv = {s_q.dpv[0], tick & dirm};
    s_d.dpl = {s_q.dpl[0], s_q.drl};
    if (s_q.dpv[1])
    begin
      s_d.dir = s_q.dpl[1];
    end

    // ==========================================================
    // compare: output toggles one cycle after match outside directional mode, flag two cycles after
    s_d.mt = {s_q.mt[0], match};
    if (s_q.mt[0] && !dirm)
    begin
      s_d.cmpo = ~s_q.cmpo;
    end
    fset[gtm_pkg::FLG_CMP] = s_q.mt[1];

    // ==========================================================
    // apb writes, access phase; software count write overrides hardware
    if (wr)
    begin
      unique case (apb_req.paddr)
        gtm_pkg::OFF_CTL:
        begin
          s_d.ctl = apb_req.pwdata[15:0];
          if (apb_req.pwdata[gtm_pkg::CTL_EN])
          begin
            // restart point: only software gets here
            s_d.up  = 1'b1;
            s_d.psc = 7'h00;
          end
        end
        gtm_pkg::OFF_PER: s_d.per = apb_req.pwdata[15:0];
        gtm_pkg::OFF_CNT: s_d.cnt = apb_req.pwdata[15:0];
        gtm_pkg::OFF_CMP: s_d.cmp = apb_req.pwdata[15:0];
        gtm_pkg::OFF_FLG: fclr    = apb_req.pwdata[3:0];
        default:          s_d.err = s_q.err;
      endcase
    end
    // hardware set wins over a clear in the same cycle
    s_d.flg = (s_q.flg & ~fclr) | fset;

    // ==========================================================
    // read data and error prepared in the setup cycle
    if (rd_setup)
    begin
      s_d.rdata = 32'h0000_0000;
      s_d.err   = 1'b0;
      unique case (apb_req.paddr)
        gtm_pkg::OFF_CTL: s_d.rdata[15:0] = s_q.ctl;
        gtm_pkg::OFF_PER: s_d.rdata[15:0] = s_q.per;
        gtm_pkg::OFF_CNT: s_d.rdata[15:0] = s_q.cnt;
        gtm_pkg::OFF_CMP: s_d.rdata[15:0] = s_q.cmp;
        gtm_pkg::OFF_GRP:
        begin
          s_d.rdata[gtm_pkg::GRP_DIR]    = dir_status;
          s_d.rdata[gtm_pkg::GRP_CMPOUT] = s_q.cmpo;
        end
        gtm_pkg::OFF_FLG: s_d.rdata[3:0] = s_q.flg;
        default:          s_d.err        = 1'b1;
      endcase
    end
  end

  // status shows the direction actually in use
  always_comb
  begin
    if (s_q.ctl[gtm_pkg::CTL_MODE +: 3] == gtm_pkg::MODE_DIR)
    begin
      dir_status = s_q.dir;
    end
    else if (s_q.ctl[gtm_pkg::CTL_MODE +: 3] == gtm_pkg::MODE_SUD)
    begin
      dir_status = s_q.up;
    end
    else
    begin
      dir_status = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (!nrst)
    begin
      s_q     <= '0;
      s_q.ctl <= gtm_pkg::CTL_RST;
      s_q.per <= gtm_pkg::PER_RST;
      s_q.up  <= 1'b1;
      s_q.dir <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);

  sequence dir_tick_s;
    tick && dirm && !wr;
  endsequence

  sequence sud_tick_s;
    tick && sudm && !wr;
  endsequence

  // internal clock, no prescale: the first tick must follow at once
  sequence ctl_start_s;
    wr && apb_req.paddr == gtm_pkg::OFF_CTL && apb_req.pwdata[gtm_pkg::CTL_EN]
      && apb_req.pwdata[gtm_pkg::CTL_CLKS +: 2] != gtm_pkg::CLKS_EXT
      && apb_req.pwdata[gtm_pkg::CTL_PRE +: 3] == 3'h0;
  endsequence

  up_hold_a: assert property (
    dir_tick_s ##0 (s_q.dir && (s_q.cnt == s_q.per || s_q.cnt == 16'hFFFF))
    |=> $stable(s_q.cnt)) else $error("directional up count did not hold");

  zero_hold_a: assert property (
    dir_tick_s ##0 (!s_q.dir && s_q.cnt == 16'h0000)
    |=> s_q.cnt == 16'h0000) else $error("directional down count left zero");

  down_step_a: assert property (
    dir_tick_s ##0 (!s_q.dir && s_q.cnt != 16'h0000)
    |=> s_q.cnt == $past(s_q.cnt) - 16'h0001) else $error("directional down step wrong");

  up_step_a: assert property (
    dir_tick_s ##0 (s_q.dir && s_q.cnt != s_q.per && s_q.cnt != 16'hFFFF)
    |=> s_q.cnt == $past(s_q.cnt) + 16'h0001) else $error("directional up step wrong");

  per_down_a: assert property (
    dir_tick_s ##0 (!s_q.dir && s_q.cnt == s_q.per && s_q.per != 16'h0000)
    |=> s_q.cnt == $past(s_q.per) - 16'h0001) else $error("no step down from period");

  dir_latency_a: assert property (
    (tick && dirm) ##1 dirm [*2]
    |=> s_q.dir == $past(s_q.drl, 3)) else $error("direction latency wrong");

  cmp_quiet_a: assert property (
    dirm && $past(dirm)
    |-> $stable(s_q.cmpo)) else $error("compare output moved in directional mode");

  cmp_toggle_a: assert property (
    match && !dirm ##1 !dirm
    |=> s_q.cmpo != $past(s_q.cmpo)) else $error("compare output did not toggle");

  dir_show_a: assert property (
    dirm
    |-> dir_status == s_q.dir) else $error("direction status wrong");

  ext_src_a: assert property (
    tick && s_q.ctl[gtm_pkg::CTL_CLKS +: 2] == gtm_pkg::CLKS_EXT
    |=> s_q.ckl && !$past(s_q.ckl)) else $error("external tick without clock edge");

  mode_gate_a: assert property (
    !dirm && !sudm && !wr
    |=> $stable(s_q.cnt)) else $error("count moved in an unsupported mode");

  sud_turn_a: assert property (
    sud_tick_s ##0 (s_q.up && s_q.cnt == s_q.per && s_q.per != 16'h0000)
    |=> !s_q.up && s_q.cnt == $past(s_q.per) - 16'h0001) else $error("no turn at period");

  sud_stop_a: assert property (
    sud_tick_s ##0 (!s_q.up && s_q.cnt == 16'h0001)
    |=> !timer_running && s_q.psc == 7'h00 ##1 $stable(s_q.cnt)) else $error("no stop at zero");

  sud_idle_a: assert property (
    !timer_running && !wr
    |=> $stable(s_q.cnt)) else $error("stopped count moved");

  sud_down_step_a: assert property (
    sud_tick_s ##0 (!s_q.up && s_q.cnt > 16'h0001)
    |=> !s_q.up && timer_running && s_q.cnt == $past(s_q.cnt) - 16'h0001) else $error("single down step wrong");

  sud_wrap_a: assert property (
    sud_tick_s ##0 (s_q.up && s_q.cnt == 16'hFFFF && s_q.per != 16'hFFFF)
    |=> s_q.up && timer_running && s_q.cnt == 16'h0000) else $error("no wrap above period");

  sud_up_step_a: assert property (
    sud_tick_s ##0 (s_q.up && s_q.cnt != s_q.per)
    |=> s_q.up && s_q.cnt == $past(s_q.cnt) + 16'h0001) else $error("single up step wrong");

  per_mid_a: assert property (
    sud_tick_s ##0 (s_q.up && s_q.cnt + 16'h0001 == s_q.per)
    |=> s_q.flg[gtm_pkg::FLG_PER]) else $error("period flag not at mid period");

  sud_show_a: assert property (
    sudm
    |-> dir_status == s_q.up) else $error("single up/down status wrong");

  start_tick_a: assert property (
    ctl_start_s
    |=> tick) else $error("counting did not start at once");

  per_flag_a: assert property (
    tick && (dirm || sudm) && nxt == s_q.per
    |=> s_q.flg[gtm_pkg::FLG_PER]) else $error("period flag missing");

  und_flag_a: assert property (
    tick && (dirm || sudm) && nxt == 16'h0000
    |=> s_q.flg[gtm_pkg::FLG_UND]) else $error("underflow flag missing");

  ovf_flag_a: assert property (
    tick && (dirm || sudm) && nxt == 16'hFFFF
    |=> s_q.flg[gtm_pkg::FLG_OVF]) else $error("overflow flag missing");

  cmp_flag_a: assert property (
    match
    |-> ##3 s_q.flg[gtm_pkg::FLG_CMP]) else $error("compare flag not two cycles after count match");

  tick_gate_a: assert property (
    tick
    |-> en && s_q.psc == psc_lim) else $error("count outside prescale end");

endmodule

/* File: verif/gtm_qep_model.sv */
`timescale 1ns/1ps

module gtm_enc_model (
  // clock
  input  wire logic       clk_sys,
  // burst request from the bench
  input  wire logic       go,
  input  wire logic [7:0] pulses,
  input  wire logic       up,
  // pins toward the timer, and busy back to the bench
  output logic            ext_clk_pin,
  output logic            count_direction_input,
  output logic            busy
);
  assign count_direction_input = up;

  // ==========================================================
  // count clock stands low between bursts, like a stopped encoder
  initial
  begin
    ext_clk_pin = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clk_sys);
      if (go)
      begin
        busy <= 1'b1;
        repeat (pulses)
        begin
          ext_clk_pin <= 1'b1;
          repeat (4) @(posedge clk_sys);
          ext_clk_pin <= 1'b0;
          repeat (4) @(posedge clk_sys);
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

/* File: verif/gp_timer_updown_modes_bench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
  begin \
    compares++; \
    if ((got) !== (ex)) \
    begin \
      bad_count++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end

module gp_timer_updown_modes_bench;
  logic                  clk_sys, nrst, go, up, busy, ext_clk_pin, count_direction_input;
  logic                  pready, pslverr, cmp_out, dir_status, timer_running, err;
  logic [7:0]            pulses;
  logic [31:0]           prdata, q;
  gtm_pkg::gtm_apb_req_t req;
  int                    bad_count, compares, n;

  gtm_timer dut (.clk_sys(clk_sys), .nrst(nrst), .apb_req(req), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ext_clk_pin(ext_clk_pin), .count_direction_input(count_direction_input),
    .cmp_out(cmp_out), .dir_status(dir_status), .timer_running(timer_running));
  gtm_enc_model enc (.clk_sys(clk_sys), .go(go), .pulses(pulses), .up(up), .ext_clk_pin(ext_clk_pin),
    .count_direction_input(count_direction_input), .busy(busy));

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // apb master, waits for pready rather than assuming zero wait
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk_sys);
    req.penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    req <= '0;
  endtask

  task automatic chk_reg(input logic [7:0] a, input logic [31:0] ex, input string nm);
    xfer(1'b0, a, 32'h0);
    `CHK(nm, ex, q)
  endtask

  function automatic logic [31:0] ctlw(input logic [2:0] m, input logic [1:0] ck, input logic [2:0] pre);
    return (32'(m) << gtm_pkg::CTL_MODE) | (32'(pre) << gtm_pkg::CTL_PRE) | (32'(ck) << gtm_pkg::CTL_CLKS)
      | (32'h1 << gtm_pkg::CTL_EN) | (32'h1 << gtm_pkg::CTL_CMPEN);
  endfunction

  // slack covers the pin synchronisers
  task automatic burst(input logic [7:0] p);
    go <= 1'b1;
    pulses <= p;
    @(posedge clk_sys);
    go <= 1'b0;
    @(posedge clk_sys);
    while (busy === 1'b1) @(posedge clk_sys);
    repeat (12) @(posedge clk_sys);
  endtask

  task automatic sud(input logic [15:0] start, input logic [15:0] per, input int ex);
    xfer(1'b1, gtm_pkg::OFF_CTL, 32'h0);
    xfer(1'b1, gtm_pkg::OFF_PER, 32'(per));
    xfer(1'b1, gtm_pkg::OFF_CNT, 32'(start));
    xfer(1'b1, gtm_pkg::OFF_FLG, 32'hF);
    xfer(1'b1, gtm_pkg::OFF_CTL, ctlw(gtm_pkg::MODE_SUD, 2'h0, 3'h0));
    n = 0;
    do
    begin
      @(negedge clk_sys);
      // count only the cycles in which the timer still runs
      if (timer_running === 1'b1)
        n++;
      if (start == 16'h0000 && n == 2) `CHK("sud dir up", 1'b1, dir_status)
      if (start == 16'h0000 && n == 6) `CHK("sud dir down", 1'b0, dir_status)
      if (start == 16'h0000 && n == 6) `CHK("sud cmp toggled", 1'b1, cmp_out)
    end
    while (timer_running === 1'b1 && n < 200);
    `CHK("sud ticks", ex, n)
    chk_reg(gtm_pkg::OFF_CNT, 32'h0, "sud end count");
  endtask

  task automatic conclude();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    conclude();
  end

  // ==========================================================
  initial
  begin
    bad_count = 0;
    compares = 0;
    nrst = 1'b0;
    req = '0;
    go = 1'b0;
    up = 1'b1;
    pulses = 8'h00;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    chk_reg(gtm_pkg::OFF_CTL, 32'h0, "ctl reset");
    chk_reg(gtm_pkg::OFF_GRP, 32'h1, "grp reset");
    xfer(1'b0, 8'h18, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, q)
    // directional, internal clock, start on a value below period
    xfer(1'b1, gtm_pkg::OFF_PER, 32'h5);
    xfer(1'b1, gtm_pkg::OFF_CMP, 32'h3);
    xfer(1'b1, gtm_pkg::OFF_CNT, 32'h3);
    xfer(1'b1, gtm_pkg::OFF_CTL, ctlw(gtm_pkg::MODE_DIR, 2'h0, 3'h0));
    xfer(1'b0, gtm_pkg::OFF_CTL, 32'h0);
    `CHK("mode field", 3'h3, q[13:11])
    repeat (20) @(posedge clk_sys);
    chk_reg(gtm_pkg::OFF_CNT, 32'h5, "dir up hold");
    chk_reg(gtm_pkg::OFF_GRP, 32'h1, "dir up status");
    chk_reg(gtm_pkg::OFF_FLG, 32'h1, "dir period flag");
    up <= 1'b0;
    repeat (30) @(posedge clk_sys);
    chk_reg(gtm_pkg::OFF_CNT, 32'h0, "dir down hold");
    `CHK("dir down status", 1'b0, dir_status)
    `CHK("dir no toggle", 1'b0, cmp_out)
    xfer(1'b0, gtm_pkg::OFF_FLG, 32'h0);
    `CHK("dir underflow flag", 1'b1, q[gtm_pkg::FLG_UND])
    // start above period, counting up
    xfer(1'b1, gtm_pkg::OFF_FLG, 32'hF);
    up <= 1'b1;
    repeat (10) @(posedge clk_sys);
    xfer(1'b1, gtm_pkg::OFF_CNT, 32'hFFF0);
    repeat (40) @(posedge clk_sys);
    chk_reg(gtm_pkg::OFF_CNT, 32'hFFFF, "above period up");
    xfer(1'b0, gtm_pkg::OFF_FLG, 32'h0);
    `CHK("overflow flag", 1'b1, q[gtm_pkg::FLG_OVF])
    // external count clock from the encoder model
    xfer(1'b1, gtm_pkg::OFF_CTL, 32'h0);
    xfer(1'b1, gtm_pkg::OFF_PER, 32'h64);
    xfer(1'b1, gtm_pkg::OFF_CNT, 32'h0);
    xfer(1'b1, gtm_pkg::OFF_CTL, ctlw(gtm_pkg::MODE_DIR, gtm_pkg::CLKS_EXT, 3'h0));
    burst(8'h06);
    chk_reg(gtm_pkg::OFF_CNT, 32'h6, "ext clock count");
    xfer(1'b1, gtm_pkg::OFF_CNT, 32'h0);
    xfer(1'b1, gtm_pkg::OFF_CTL, ctlw(gtm_pkg::MODE_DIR, gtm_pkg::CLKS_EXT, 3'h1));
    burst(8'h06);
    chk_reg(gtm_pkg::OFF_CNT, 32'h3, "prescaled count");
    // single up/down, direction pin held low and ignored
    up <= 1'b0;
    sud(16'h0000, 16'h0004, 8);
    xfer(1'b0, gtm_pkg::OFF_FLG, 32'h0);
    `CHK("sud flags", 2'h3, q[1:0])
    sud(16'hFFFE, 16'h0003, 8);
    sud(16'h0003, 16'h0003, 3);
    sud(16'h0001, 16'h0004, 7);
    repeat (10) @(posedge clk_sys);
    chk_reg(gtm_pkg::OFF_CNT, 32'h0, "stays stopped");
    xfer(1'b0, gtm_pkg::OFF_CTL, 32'h0);
    `CHK("enable cleared", 1'b0, q[gtm_pkg::CTL_EN] | timer_running)
    conclude();
  end
endmodule
